// >>> pkg/psp_consts.svh
// Constants of the pipelined burst static memory port
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH

`define PSP_ADDR_W     17
`define PSP_DEPTH      131072
`define PSP_DATA_W     32
`define PSP_NBYTES     4
`define PSP_BYTE_W     9
`define PSP_WORD_W     36
`define PSP_BEAT_W     2
`define PSP_LAST_BEAT  2'h3
`define PSP_PIPE_LAT   2

`define PSP_RST_ADDR   17'h00000
`define PSP_RST_WORD   36'h000000000
`define PSP_RST_MASK   4'h0
`define PSP_RST_BEAT   2'h0

`endif

// >>> pkg/psp_pkg.sv
// Types of the pipelined burst static memory port
`include "psp_consts.svh"

package psp_pkg;

  typedef logic [`PSP_ADDR_W-1:0] psp_addr_t;
  typedef logic [`PSP_WORD_W-1:0] psp_word_t;
  typedef logic [`PSP_NBYTES-1:0] psp_mask_t;
  typedef logic [`PSP_BEAT_W-1:0] psp_beat_t;

  typedef enum logic [1:0] {
    PSP_IDLE  = 2'b00,
    PSP_READ  = 2'b01,
    PSP_WRITE = 2'b10
  } psp_burst_t;

  typedef struct packed {
    psp_burst_t mode;
    psp_addr_t  base;
    psp_beat_t  beat;
    logic       s1_valid;
    logic       s1_read;
    psp_addr_t  s1_addr;
    psp_mask_t  s1_mask;
    logic       s2_valid;
    logic       s2_read;
    psp_addr_t  s2_addr;
    psp_mask_t  s2_mask;
    logic       fwd_hit;
    psp_word_t  fwd_data;
    psp_mask_t  fwd_mask;
    psp_word_t  out_word;
    logic       drive;
  } psp_state_t;

endpackage

// >>> hw/psp_mem.sv
// Memory array with byte writes and a registered read port
`timescale 1ns/10ps
`include "psp_consts.svh"

module psp_mem
  import psp_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      write_en,
  input  wire psp_addr_t write_addr,
  input  wire psp_mask_t write_mask,
  input  wire psp_word_t write_data,
  input  wire logic      read_en,
  input  wire psp_addr_t read_addr,
  output psp_word_t      read_data
);

  psp_word_t array [0:`PSP_DEPTH-1];

  // Read during write to one address returns the old word; the caller forwards
  always_ff @(posedge clock) begin
    if (read_en) begin
      read_data <= array[read_addr];
    end
    for (int k = 0; k < `PSP_NBYTES; k++) begin
      if (write_en && write_mask[k]) begin
        array[write_addr][k*`PSP_BYTE_W +: `PSP_BYTE_W] <= write_data[k*`PSP_BYTE_W +: `PSP_BYTE_W];
      end
    end
  end

endmodule

// >>> hw/psp_port.sv
// Pipelined burst static memory port: command pipeline, burst counter, data path
`timescale 1ns/10ps
`include "psp_consts.svh"

module psp_port
  import psp_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   clock_enable_n,
  input  wire logic                   select_a_n,
  input  wire logic                   select_b_n,
  input  wire logic                   select_active_high,
  input  wire logic                   advance_or_load_n,
  input  wire logic                   read_not_write,
  input  wire logic [`PSP_NBYTES-1:0] byte_write_n,
  input  wire logic                   burst_order_linear_n,
  input  wire logic                   output_enable_n,
  input  wire logic [`PSP_ADDR_W-1:0] address_inputs,
  input  wire logic [`PSP_DATA_W-1:0] data_lines_in,
  input  wire logic [`PSP_NBYTES-1:0] parity_data_lines_in,
  output logic      [`PSP_DATA_W-1:0] data_lines_out,
  output logic      [`PSP_NBYTES-1:0] parity_data_lines_out,
  output logic                        data_lines_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Word packing
  ////////////////////////////////////////////////////////////////////////////

  // Byte k of the word is its parity bit above its eight data bits
  function automatic psp_word_t pack_word(
    input logic [`PSP_DATA_W-1:0] d,
    input logic [`PSP_NBYTES-1:0] p
  );
    psp_word_t w;
    w = `PSP_RST_WORD;
    for (int k = 0; k < `PSP_NBYTES; k++) begin
      w[k*`PSP_BYTE_W +: `PSP_BYTE_W] = {p[k], d[k*8 +: 8]};
    end
    return w;
  endfunction

  function automatic logic [`PSP_DATA_W-1:0] word_data(input psp_word_t w);
    logic [`PSP_DATA_W-1:0] d;
    d = '0;
    for (int k = 0; k < `PSP_NBYTES; k++) begin
      d[k*8 +: 8] = w[k*`PSP_BYTE_W +: 8];
    end
    return d;
  endfunction

  function automatic logic [`PSP_NBYTES-1:0] word_parity(input psp_word_t w);
    logic [`PSP_NBYTES-1:0] p;
    p = '0;
    for (int k = 0; k < `PSP_NBYTES; k++) begin
      p[k] = w[k*`PSP_BYTE_W + 8];
    end
    return p;
  endfunction

  // Bytes still in flight to the array replace the stale bytes just read
  function automatic psp_word_t merge_word(
    input psp_word_t old_w,
    input psp_word_t new_w,
    input psp_mask_t mask
  );
    psp_word_t w;
    w = old_w;
    for (int k = 0; k < `PSP_NBYTES; k++) begin
      if (mask[k]) begin
        w[k*`PSP_BYTE_W +: `PSP_BYTE_W] = new_w[k*`PSP_BYTE_W +: `PSP_BYTE_W];
      end
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Burst address
  ////////////////////////////////////////////////////////////////////////////

  // Only the two low bits move, so a burst never leaves its aligned group of four
  function automatic psp_addr_t burst_addr(
    input psp_addr_t base,
    input psp_beat_t beat,
    input logic      interleaved
  );
    psp_beat_t low;
    low = interleaved ? (base[`PSP_BEAT_W-1:0] ^ beat)
                      : psp_beat_t'(base[`PSP_BEAT_W-1:0] + beat);
    return {base[`PSP_ADDR_W-1:`PSP_BEAT_W], low};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////////

  psp_state_t state;
  psp_state_t next_state;

  psp_word_t  word_in;
  psp_word_t  mem_read_data;
  logic       mem_write_en;
  logic       mem_read_en;

  logic       selected;
  logic       issue;
  logic       issue_read;
  psp_addr_t  issue_addr;
  psp_mask_t  issue_mask;
  psp_beat_t  beat_next;

  // Write data is taken straight off the lines on the edge that writes the array
  assign word_in = pack_word(data_lines_in, parity_data_lines_in);

  // The array only moves on enabled edges, as the pipeline does
  assign mem_write_en = !clock_enable_n && state.s2_valid && !state.s2_read;
  assign mem_read_en  = !clock_enable_n && state.s1_valid && state.s1_read;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    selected   = !select_a_n && !select_b_n && select_active_high;
    issue      = 1'b0;
    issue_read = 1'b0;
    issue_addr = state.base;
    issue_mask = `PSP_RST_MASK;
    beat_next  = psp_beat_t'(state.beat + 2'h1);

    // Outside reset, a suspended edge leaves every field untouched
    if (!clock_enable_n) begin
      //////////////////////// Command stage
      if (!advance_or_load_n) begin
        if (selected) begin
          next_state.base = address_inputs;
          next_state.beat = `PSP_RST_BEAT;
          next_state.mode = read_not_write ? PSP_READ : PSP_WRITE;
          issue           = 1'b1;
          issue_read      = read_not_write;
          issue_addr      = address_inputs;
        end else begin
          // Deselect ends the burst but keeps the stages below moving
          next_state.mode = PSP_IDLE;
        end
      end else if (state.mode != PSP_IDLE) begin
        // Address inputs are not looked at here
        if (state.beat == `PSP_LAST_BEAT) begin
          next_state.mode = PSP_IDLE;
        end else begin
          next_state.beat = beat_next;
          issue           = 1'b1;
          issue_read      = (state.mode == PSP_READ);
          issue_addr      = burst_addr(state.base, beat_next,
                                       burst_order_linear_n);
        end
      end

      // Byte selects count only for writes, on loads and burst beats alike
      if (issue && !issue_read) begin
        issue_mask = ~byte_write_n;
      end

      //////////////////////// Pipeline stages
      next_state.s1_valid = issue;
      next_state.s1_read  = issue_read;
      next_state.s1_addr  = issue_addr;
      next_state.s1_mask  = issue_mask;

      // The second stage takes whatever was pending, selected or not
      next_state.s2_valid = state.s1_valid;
      next_state.s2_read  = state.s1_read;
      next_state.s2_addr  = state.s1_addr;
      next_state.s2_mask  = state.s1_mask;

      //////////////////////// Read after write forwarding
      // A read one cycle behind a write to the same word reads the array on the
      // very edge that writes it, so the written bytes are kept aside
      next_state.fwd_hit  = state.s1_valid && state.s1_read &&
                            state.s2_valid && !state.s2_read &&
                            (state.s1_addr == state.s2_addr);
      next_state.fwd_data = word_in;
      next_state.fwd_mask = state.s2_mask;

      //////////////////////// Output register
      // Drive only for a read two edges after its command; writes and idle
      // cycles release the lines at the same point
      next_state.drive = state.s2_valid && state.s2_read;
      if (state.s2_valid && state.s2_read) begin
        next_state.out_word = merge_word(mem_read_data, state.fwd_data,
                                         state.fwd_hit ? state.fwd_mask
                                                       : `PSP_RST_MASK);
      end
    end

    if (!rst_b) begin
      next_state.mode     = PSP_IDLE;
      next_state.base     = `PSP_RST_ADDR;
      next_state.beat     = `PSP_RST_BEAT;
      next_state.s1_valid = 1'b0;
      next_state.s1_read  = 1'b0;
      next_state.s1_addr  = `PSP_RST_ADDR;
      next_state.s1_mask  = `PSP_RST_MASK;
      next_state.s2_valid = 1'b0;
      next_state.s2_read  = 1'b0;
      next_state.s2_addr  = `PSP_RST_ADDR;
      next_state.s2_mask  = `PSP_RST_MASK;
      next_state.fwd_hit  = 1'b0;
      next_state.fwd_data = `PSP_RST_WORD;
      next_state.fwd_mask = `PSP_RST_MASK;
      next_state.out_word = `PSP_RST_WORD;
      next_state.drive    = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array
  ////////////////////////////////////////////////////////////////////////////

  psp_mem u_mem (
    .clock      (clock),
    .write_en   (mem_write_en),
    .write_addr (state.s2_addr),
    .write_mask (state.s2_mask),
    .write_data (word_in),
    .read_en    (mem_read_en),
    .read_addr  (state.s1_addr),
    .read_data  (mem_read_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  ////////////////////////////////////////////////////////////////////////////

  assign data_lines_out        = word_data(state.out_word);
  assign parity_data_lines_out = word_parity(state.out_word);

  // Output enable is asynchronous by nature, so it gates the registered drive
  assign data_lines_oe_n = !state.drive || output_enable_n;

endmodule

// >>> bench/psp_port_monitor.sv
// Checker of the burst memory port pins
`timescale 1ns/10ps
`include "psp_consts.svh"
module psp_port_monitor (
  input wire logic                   clock,
  input wire logic                   rst_b,
  input wire logic                   clock_enable_n,
  input wire logic                   select_a_n,
  input wire logic                   select_b_n,
  input wire logic                   select_active_high,
  input wire logic                   advance_or_load_n,
  input wire logic                   read_not_write,
  input wire logic                   output_enable_n,
  input wire logic [`PSP_DATA_W-1:0] data_lines_out,
  input wire logic [`PSP_NBYTES-1:0] parity_data_lines_out,
  input wire logic                   data_lines_oe_n
);
  wire logic sel = !select_a_n && !select_b_n && select_active_high;
  wire logic ld  = !clock_enable_n && !advance_or_load_n;
  wire logic rd  = ld && sel && read_not_write;
  wire logic wr  = ld && sel && !read_not_write;
  wire logic ds  = ld && !sel;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_oe_gate; output_enable_n |-> data_lines_oe_n; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive with output enable off");
  property p_hold; clock_enable_n |=> $stable({parity_data_lines_out, data_lines_out}); endproperty
  a_hold: assert property (p_hold) else $error("data moved on suspended edge");
  property p_hold_oe; clock_enable_n ##1 $stable(output_enable_n) |-> $stable(data_lines_oe_n);
  endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("drive moved on suspended edge");
  property p_wr_float; wr ##1 !clock_enable_n ##1 !clock_enable_n |=> data_lines_oe_n; endproperty
  a_wr_float: assert property (p_wr_float) else $error("bus driven in write slot");
  property p_ds_float; ds ##1 !clock_enable_n ##1 !clock_enable_n |=> data_lines_oe_n; endproperty
  a_ds_float: assert property (p_ds_float) else $error("bus driven after deselect");
  property p_rd_drive;
    rd ##1 !clock_enable_n ##1 !clock_enable_n ##1 !output_enable_n |-> !data_lines_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  property p_turn; rd ##1 wr ##1 !clock_enable_n ##1 (!clock_enable_n && !output_enable_n)
    |-> !data_lines_oe_n ##1 data_lines_oe_n; endproperty
  a_turn: assert property (p_turn) else $error("bad read to write turnaround");
  property p_ds_adv; ds ##1 (!clock_enable_n && advance_or_load_n) ##1 !clock_enable_n
    ##1 !clock_enable_n |=> data_lines_oe_n; endproperty
  a_ds_adv: assert property (p_ds_adv) else $error("burst went on after deselect");
endmodule

bind psp_port psp_port_monitor i_psp_port_monitor (
  .clock(clock), .rst_b(rst_b), .clock_enable_n(clock_enable_n), .select_a_n(select_a_n),
  .select_b_n(select_b_n), .select_active_high(select_active_high),
  .advance_or_load_n(advance_or_load_n), .read_not_write(read_not_write),
  .output_enable_n(output_enable_n), .data_lines_out(data_lines_out),
  .parity_data_lines_out(parity_data_lines_out), .data_lines_oe_n(data_lines_oe_n)
);

// >>> bench/psp_ctl_model.sv
// Controller side data bus model: drives write data for the port
`timescale 1ns/10ps
`include "psp_consts.svh"
module psp_ctl_model (
  input  wire logic                   clock,
  input  wire logic                   clock_enable_n,
  input  wire logic                   wr_go,
  input  wire logic [35:0]            wr_word,
  output logic      [`PSP_DATA_W-1:0] data_lines_in,
  output logic      [`PSP_NBYTES-1:0] parity_data_lines_in
);
  logic        v1 = 1'b0;
  logic        v2 = 1'b0;
  logic [35:0] w1, w2;
  logic [35:0] idle_pat = 36'h0;
  // Data is due two enabled edges after its command; suspended edges do not count
  always @(posedge clock) begin
    idle_pat <= ~idle_pat;
    if (!clock_enable_n) begin
      v1 <= wr_go;
      w1 <= wr_word;
      v2 <= v1;
      w2 <= w1;
    end
  end
  // A released bus toggles, so stale data can never pass for a write
  assign {parity_data_lines_in, data_lines_in} = v2 ? w2 : idle_pat;
endmodule

// >>> bench/tb_top.sv
// Testbench of the pipelined burst memory port
`timescale 1ns/10ps
`include "psp_consts.svh"
module tb_top
  import psp_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b, clock_enable_n, select_a_n, select_b_n, select_active_high;
  logic advance_or_load_n, read_not_write, burst_order_linear_n, output_enable_n;
  logic wr_go, chk_on, cur_rd, p1, p2, p3, data_lines_oe_n;
  psp_mask_t byte_write_n;
  psp_addr_t address_inputs;
  logic [35:0] wr_word, cur_val, v1, v2, v3;
  logic [`PSP_DATA_W-1:0] data_lines_in, data_lines_out;
  logic [`PSP_NBYTES-1:0] parity_data_lines_in, parity_data_lines_out;
  logic [35:0] mem [psp_addr_t];
  logic [2:0] dsel [3] = '{3'b101, 3'b011, 3'b000};
  int errors, num_checks, cyc, n;
  psp_port i_psp_port (.clock(clock), .rst_b(rst_b), .clock_enable_n(clock_enable_n),
    .select_a_n(select_a_n), .select_b_n(select_b_n), .select_active_high(select_active_high),
    .advance_or_load_n(advance_or_load_n), .read_not_write(read_not_write),
    .byte_write_n(byte_write_n), .burst_order_linear_n(burst_order_linear_n),
    .output_enable_n(output_enable_n), .address_inputs(address_inputs),
    .data_lines_in(data_lines_in), .parity_data_lines_in(parity_data_lines_in),
    .data_lines_out(data_lines_out), .parity_data_lines_out(parity_data_lines_out),
    .data_lines_oe_n(data_lines_oe_n));
  psp_ctl_model i_psp_ctl_model (.clock(clock), .clock_enable_n(clock_enable_n), .wr_go(wr_go),
    .wr_word(wr_word), .data_lines_in(data_lines_in),
    .parity_data_lines_in(parity_data_lines_in));
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Expected word is fixed when the command is issued, so forwarding is covered too
  task automatic step(input psp_burst_t k, input logic l, input psp_addr_t pa,
                      input psp_addr_t ea, input psp_mask_t bw, input logic [2:0] s);
    logic [35:0] wd, m;
    n++;
    wd = {ea[3:0] ^ n[3:0], n[15:0], ea[15:0]};
    m = '0;
    for (int i = 0; i < 4; i++) if (!bw[i]) m = m | ({27'h0, 9'h1FF} << (9 * i));
    m = {m[35], m[26], m[17], m[8], m[34:27], m[25:18], m[16:9], m[7:0]};
    if (k == PSP_WRITE) mem[ea] = (mem[ea] & ~m) | (wd & m);
    @(posedge clock);
    clock_enable_n <= 1'b0;
    advance_or_load_n <= l;
    {select_a_n, select_b_n, select_active_high} <= s;
    read_not_write <= (k != PSP_WRITE);
    address_inputs <= pa;
    byte_write_n <= bw;
    wr_go <= (k == PSP_WRITE);
    wr_word <= wd;
    cur_rd <= (k == PSP_READ);
    cur_val <= (k == PSP_READ) ? mem[ea] : 36'h0;
  endtask
  task automatic one(input psp_burst_t k, input psp_addr_t a, input psp_mask_t bw);
    step(k, 1'b0, a, a, bw, 3'b001);
  endtask
  task automatic idle(input int c);
    repeat (c) step(PSP_IDLE, 1'b0, 17'h0, 17'h0, 4'hF, 3'b101);
  endtask
  // Suspended edge with the load, write, address and write data inputs set to do harm
  task automatic stall();
    @(posedge clock);
    clock_enable_n <= 1'b1;
    advance_or_load_n <= 1'b0;
    read_not_write <= 1'b0;
    address_inputs <= 17'h1FFFF;
    wr_go <= 1'b1;
  endtask
  task automatic burst(input psp_burst_t k, input psp_addr_t b, input logic il);
    psp_addr_t ea;
    for (int i = 0; i < 4; i++) begin
      ea = {b[16:2], il ? b[1:0] ^ 2'(i) : b[1:0] + 2'(i)};
      step(k, i != 0, (i == 0) ? b : ~b, ea, 4'h0, 3'b001);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
    if (!rst_b) {p1, p2, p3} <= 3'h0;
    else if (!clock_enable_n) {p1, v1, p2, v2, p3, v3} <= {cur_rd, cur_val, p1, v1, p2, v2};
  always @(negedge clock)
    if (chk_on) begin
      chk("drive", data_lines_oe_n, !p3 || output_enable_n);
      if (p3) chk("read data", {parity_data_lines_out, data_lines_out}, v3);
    end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    {rst_b, clock_enable_n, chk_on, wr_go, cur_rd, wr_word, cur_val} = '0;
    {select_a_n, select_b_n, select_active_high, advance_or_load_n} = 4'h5;
    // Linear order first: the opening bursts expect it
    {read_not_write, byte_write_n, burst_order_linear_n, output_enable_n} = 7'h3C;
    address_inputs = 17'h0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    chk_on <= 1'b1;
    #1 chk("reset data", data_lines_out, 36'h0);
    one(PSP_WRITE, 17'h00010, 4'h0);
    one(PSP_WRITE, 17'h00011, 4'h0);
    one(PSP_WRITE, 17'h00010, 4'hA);
    one(PSP_READ, 17'h00010, 4'h0);
    one(PSP_WRITE, 17'h00011, 4'h5);
    one(PSP_READ, 17'h00011, 4'h0);
    one(PSP_READ, 17'h00011, 4'h0);
    idle(3);
    $display("words test done");
    burst(PSP_WRITE, 17'h00101, 1'b0);
    burst(PSP_READ, 17'h00102, 1'b0);
    idle(1);
    burst_order_linear_n <= 1'b1;
    burst(PSP_READ, 17'h00103, 1'b1);
    burst(PSP_WRITE, 17'h00106, 1'b1);
    step(PSP_IDLE, 1'b1, 17'h00106, 17'h0, 4'h0, 3'b001);
    idle(1);
    burst_order_linear_n <= 1'b0;
    burst(PSP_READ, 17'h00104, 1'b0);
    idle(3);
    $display("burst test done");
    foreach (dsel[i]) begin
      burst(PSP_READ, 17'h00100, 1'b0);
      // Cut a burst after two beats; the pending beat must still come out
      step(PSP_READ, 1'b0, 17'h00100, 17'h00100, 4'h0, 3'b001);
      step(PSP_READ, 1'b1, 17'h1FEFF, 17'h00101, 4'h0, 3'b001);
      step(PSP_IDLE, 1'b0, 17'h00100, 17'h0, 4'h0, dsel[i]);
      step(PSP_IDLE, 1'b1, 17'h00100, 17'h0, 4'h0, 3'b001);
      idle(2);
    end
    $display("deselect test done");
    one(PSP_READ, 17'h00010, 4'h0);
    stall();
    one(PSP_READ, 17'h00011, 4'h0);
    stall();
    stall();
    one(PSP_WRITE, 17'h00012, 4'h0);
    stall();
    one(PSP_READ, 17'h00012, 4'h0);
    // Output enable is held off across the very cycle the read data stand
    idle(2);
    output_enable_n <= 1'b1;
    idle(2);
    output_enable_n <= 1'b0;
    idle(2);
    $display("suspend test done");
    end_sim();
  end
endmodule
